//--- rtl/fireq_top.sv
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps
module fireq_top
  import fireq_pkg::*;
(
  // Clock and reset
  input  wire logic                    CLOCK_I,
  input  wire logic                    NRST_I,
  // Avalon-MM slave
  input  wire logic [FIREQ_ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic                    AVS_READ_I,
  input  wire logic                    AVS_WRITE_I,
  input  wire logic [31:0]             AVS_WRITEDATA_I,
  input  wire logic [3:0]              AVS_BYTEENABLE_I,
  output logic      [31:0]             AVS_READDATA_O,
  output logic                         AVS_WAITREQUEST_O,
  output logic      [1:0]              AVS_RESPONSE_O,
  // Sample stream in
  input  wire fireq_samp_t             SAMP_DATA_I,
  input  wire logic                    SAMP_VALID_I,
  output logic                         SAMP_READY_O,
  // Filtered stream out
  output fireq_result_t                RES_DATA_O,
  output logic                         RES_VALID_O,
  input  wire logic                    RES_READY_I
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ************************************************************
  // Register file
  // ************************************************************
  // Tap registers other than those here belong to neighbouring blocks;
  // unheld channel A taps and channel B taps 5..8 are modelled as zero.
  logic [FIREQ_REG_W-1:0]  reg_a8;
  logic [FIREQ_REG_W-1:0]  reg_b [4];
  logic [FIREQ_CREG_W-1:0] reg_b4;
  logic                    dual_mode;

  fireq_bus_t              bus_state;
  fireq_bus_t              next_bus_state;
  logic [11:0]             reg_index;
  logic                    access;
  logic                    hit_a8;
  logic                    hit_b4;
  logic                    hit_ctrl;
  logic                    hit_stat;
  logic [3:0]              hit_b;
  logic                    mapped;
  logic                    wr_take;
  logic [31:0]             rd_mux;
  logic [31:0]             wr_a8;
  logic [31:0]             wr_b4;
  logic [31:0]             wr_b [4];
  // Buffer fill, declared here because the status read shows it
  logic [1:0]              res_cnt;

  function automatic logic [31:0] fireq_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Sign comes from bit 11; reserved bits above it never reach the filter
  function automatic logic signed [FIREQ_CTR_W-1:0] fireq_weight(input logic [FIREQ_REG_W-1:0] v);
    return FIREQ_CTR_W'($signed(v[FIREQ_COEF_W-1:0]));
  endfunction

  // Byte address is four times the register index
  assign reg_index = AVS_ADDRESS_I[13:2];
  assign access    = AVS_READ_I | AVS_WRITE_I;
  assign hit_a8    = (reg_index == FIREQ_IDX_A8);
  assign hit_b4    = (reg_index == FIREQ_IDX_B4);
  assign hit_ctrl  = (reg_index == FIREQ_IDX_CTRL);
  assign hit_stat  = (reg_index == FIREQ_IDX_STATUS);
  assign hit_b[0]  = (reg_index == FIREQ_IDX_B0);
  assign hit_b[1]  = (reg_index == FIREQ_IDX_B1);
  assign hit_b[2]  = (reg_index == FIREQ_IDX_B2);
  assign hit_b[3]  = (reg_index == FIREQ_IDX_B3);
  assign mapped    = hit_a8 | hit_b4 | hit_ctrl | hit_stat | (|hit_b);
  // One wait state: the request is taken on the second edge after it appears
  assign wr_take   = (bus_state == FIREQ_BUS_RESP) & AVS_WRITE_I & mapped;
  assign AVS_WAITREQUEST_O = access & (bus_state == FIREQ_BUS_IDLE);

  always_comb begin
    next_bus_state = FIREQ_BUS_IDLE;
    unique case (bus_state)
      FIREQ_BUS_IDLE: begin
        next_bus_state = access ? FIREQ_BUS_RESP : FIREQ_BUS_IDLE;
      end
      FIREQ_BUS_RESP: begin
        next_bus_state = FIREQ_BUS_IDLE;
      end
      default: begin
        next_bus_state = FIREQ_BUS_IDLE;
      end
    endcase
  end

  assign rd_mux = hit_a8   ? {16'h0000, reg_a8} :
                  hit_b[0] ? {16'h0000, reg_b[0]} :
                  hit_b[1] ? {16'h0000, reg_b[1]} :
                  hit_b[2] ? {16'h0000, reg_b[2]} :
                  hit_b[3] ? {16'h0000, reg_b[3]} :
                  hit_b4   ? {8'h00, reg_b4} :
                  hit_ctrl ? {31'h0000_0000, dual_mode} :
                  hit_stat ? {30'h0000_0000, res_cnt} :
                  32'h0000_0000;

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      bus_state      <= FIREQ_BUS_IDLE;
      AVS_READDATA_O <= 32'h0000_0000;
      AVS_RESPONSE_O <= 2'b00;
    end else begin
      bus_state      <= next_bus_state;
      AVS_READDATA_O <= rd_mux;
      // Unmapped addresses answer with DECODEERROR; writes there are dropped
      AVS_RESPONSE_O <= mapped ? 2'b00 : 2'b11;
    end
  end

  // Byte lanes not enabled keep the register's current contents
  assign wr_a8 = fireq_merge({16'h0000, reg_a8}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  assign wr_b4 = fireq_merge({8'h00, reg_b4}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);

  // Reserved bits 15:12 (23:18) are read/write storage
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      reg_a8    <= FIREQ_REG_RST;
      reg_b4    <= FIREQ_CREG_RST;
      dual_mode <= FIREQ_CTRL_RST;
    end else if (wr_take) begin
      if (hit_a8) reg_a8 <= wr_a8[FIREQ_REG_W-1:0];
      if (hit_b4) reg_b4 <= wr_b4[FIREQ_CREG_W-1:0];
      if (hit_ctrl && AVS_BYTEENABLE_I[0]) dual_mode <= AVS_WRITEDATA_I[FIREQ_CTRL_DUAL];
    end
  end

  generate
    for (genvar g = 0; g < 4; g++) begin : g_breg
      assign wr_b[g] = fireq_merge({16'h0000, reg_b[g]}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
          reg_b[g] <= FIREQ_REG_RST;
        end else if (wr_take && hit_b[g]) begin
          reg_b[g] <= wr_b[g][FIREQ_REG_W-1:0];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Tap weight mapping
  // ************************************************************
  logic signed [FIREQ_CTR_W-1:0] wa [FIREQ_TAPS];
  logic signed [FIREQ_CTR_W-1:0] wb [FIREQ_TAPS];

  generate
    for (genvar t = 0; t < FIREQ_TAPS; t++) begin : g_wmap
      if (t == 8) begin : g_a8
        // Same register serves channel A in both dual and single mode
        assign wa[t] = fireq_weight(reg_a8);
      end else begin : g_az
        assign wa[t] = '0;
      end
      if (t < 4) begin : g_bl
        // Channel B taps only count in dual mode
        assign wb[t] = dual_mode ? fireq_weight(reg_b[t]) : '0;
      end else if (t == FIREQ_CTR_TAP) begin : g_bc
        assign wb[t] = dual_mode ? $signed(reg_b4[FIREQ_CTR_W-1:0]) : '0;
      end else begin : g_bz
        assign wb[t] = '0;
      end
    end
  endgenerate

  // ************************************************************
  // Delay lines and multiply-accumulate
  // ************************************************************
  logic signed [FIREQ_SAMP_W-1:0] dl_a [FIREQ_TAPS];
  logic signed [FIREQ_SAMP_W-1:0] dl_b [FIREQ_TAPS];
  logic signed [FIREQ_ACC_W-1:0]  sum_a;
  logic signed [FIREQ_ACC_W-1:0]  sum_b;
  logic                           samp_take;

  assign samp_take = SAMP_VALID_I & SAMP_READY_O;

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < FIREQ_TAPS; i++) begin
        dl_a[i] <= '0;
        dl_b[i] <= '0;
      end
    end else if (samp_take) begin
      dl_a[0] <= SAMP_DATA_I.a;
      dl_b[0] <= SAMP_DATA_I.b;
      for (int i = 1; i < FIREQ_TAPS; i++) begin
        dl_a[i] <= dl_a[i-1];
        dl_b[i] <= dl_b[i-1];
      end
    end
  end

  // Full-precision sum: 12x18 products plus six bits of growth
  always_comb begin
    sum_a = '0;
    sum_b = '0;
    for (int i = 0; i < FIREQ_TAPS; i++) begin
      sum_a = sum_a + FIREQ_ACC_W'(dl_a[i] * wa[i]);
      sum_b = sum_b + FIREQ_ACC_W'(dl_b[i] * wb[i]);
    end
  end

  // Result valid one cycle after the newest sample enters the line
  logic calc_valid;
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      calc_valid <= 1'b0;
    end else begin
      calc_valid <= samp_take;
    end
  end

  // ************************************************************
  // Two-entry output buffer
  // ************************************************************
  // Input is stalled while the buffer cannot absorb an in-flight result
  fireq_result_t buf_mem [FIREQ_BUF_DEPTH];
  logic          wr_ptr;
  logic          rd_ptr;
  logic          buf_push;
  logic          buf_pop;

  assign buf_push     = calc_valid;
  assign buf_pop      = RES_VALID_O & RES_READY_I;
  assign RES_VALID_O  = (res_cnt != 2'd0);
  assign RES_DATA_O   = buf_mem[rd_ptr];
  // Trade-off: ready waits out an in-flight sum, so intake is two samples in three cycles at best
  assign SAMP_READY_O = rst_n & (res_cnt == 2'd0 || (res_cnt == 2'd1 && !calc_valid));

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      res_cnt <= 2'd0;
      for (int i = 0; i < FIREQ_BUF_DEPTH; i++) begin
        buf_mem[i] <= '0;
      end
    end else begin
      if (buf_push) begin
        buf_mem[wr_ptr] <= '{a: sum_a, b: sum_b};
        wr_ptr          <= ~wr_ptr;
      end
      if (buf_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      res_cnt <= 2'(res_cnt + {1'b0, buf_push} - {1'b0, buf_pop});
    end
  end

endmodule

//--- inc/fireq_pkg.sv
package fireq_pkg;

  // ************************************************************
  // Register map (register indices)
  // ************************************************************
  // Printed offsets are not all multiples of four, so each is an index
  localparam logic [11:0] FIREQ_IDX_B0     = 12'h0448;
  localparam logic [11:0] FIREQ_IDX_B1     = 12'h044A;
  localparam logic [11:0] FIREQ_IDX_B2     = 12'h044C;
  localparam logic [11:0] FIREQ_IDX_B3     = 12'h044E;
  localparam logic [11:0] FIREQ_IDX_B4     = 12'h0450;
  localparam logic [11:0] FIREQ_IDX_A8     = 12'h0429;
  localparam logic [11:0] FIREQ_IDX_CTRL   = 12'h0460;
  localparam logic [11:0] FIREQ_IDX_STATUS = 12'h0461;
  localparam int          FIREQ_ADDR_W     = 14;

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int          FIREQ_COEF_W     = 12;
  localparam int          FIREQ_CTR_W      = 18;
  localparam int          FIREQ_REG_W      = 16;
  localparam int          FIREQ_CREG_W     = 24;
  localparam int          FIREQ_TAPS       = 9;
  localparam int          FIREQ_CTR_TAP    = 4;
  localparam int          FIREQ_SAMP_W     = 12;
  localparam int          FIREQ_ACC_W      = 36;
  localparam logic [15:0] FIREQ_REG_RST    = 16'h0000;
  localparam logic [23:0] FIREQ_CREG_RST   = 24'h00_0000;
  localparam int          FIREQ_CTRL_DUAL  = 0;
  localparam logic        FIREQ_CTRL_RST   = 1'b1;
  localparam int          FIREQ_BUF_DEPTH  = 2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic signed [FIREQ_SAMP_W-1:0] a;
    logic signed [FIREQ_SAMP_W-1:0] b;
  } fireq_samp_t;

  typedef struct packed {
    logic signed [FIREQ_ACC_W-1:0] a;
    logic signed [FIREQ_ACC_W-1:0] b;
  } fireq_result_t;

  typedef enum logic [1:0] {
    FIREQ_BUS_IDLE = 2'b01,
    FIREQ_BUS_RESP = 2'b10
  } fireq_bus_t;

endpackage

//--- bench/fireq_assertions.sv
`timescale 1ns/100ps
module fireq_assertions
  import fireq_pkg::*;
(
  // Clock, reset and bus
  input wire logic                    CLOCK_I,
  input wire logic                    NRST_I,
  input wire logic [FIREQ_ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic                    AVS_READ_I,
  input wire logic                    AVS_WRITE_I,
  input wire logic [31:0]             AVS_READDATA_O,
  input wire logic                    AVS_WAITREQUEST_O,
  input wire logic [1:0]              AVS_RESPONSE_O,
  // Streams
  input wire logic                    SAMP_VALID_I,
  input wire logic                    SAMP_READY_O,
  input wire fireq_result_t           RES_DATA_O,
  input wire logic                    RES_VALID_O,
  input wire logic                    RES_READY_I
);
  wire logic [11:0] idx;
  wire logic        narrow, centre, mapped, rd_done, take, pop;
  logic      [2:0]  held;
  assign idx = AVS_ADDRESS_I[13:2];
  assign narrow = idx inside {FIREQ_IDX_B0, FIREQ_IDX_B1, FIREQ_IDX_B2, FIREQ_IDX_B3, FIREQ_IDX_A8};
  assign centre = idx == FIREQ_IDX_B4;
  assign mapped = narrow | centre | idx == FIREQ_IDX_CTRL | idx == FIREQ_IDX_STATUS;
  assign rd_done = AVS_READ_I & ~AVS_WAITREQUEST_O;
  assign take = SAMP_VALID_I & SAMP_READY_O;
  assign pop = RES_VALID_O & RES_READY_I;
  // Samples taken but not yet handed on; a third would overrun the two-entry buffer
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      held <= 3'h0;
    end else begin
      held <= held + {2'h0, take} - {2'h0, pop};
    end
  end
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_stall; AVS_WAITREQUEST_O; endsequence
  sequence s_answer; !AVS_WAITREQUEST_O; endsequence
  property p_wait_first; $rose(AVS_READ_I | AVS_WRITE_I) |-> s_stall ##1 s_answer; endproperty
  property p_unmapped; rd_done && !mapped |-> AVS_RESPONSE_O == 2'h3 && AVS_READDATA_O == 32'h0000_0000; endproperty
  property p_mapped_ok; rd_done && mapped |-> AVS_RESPONSE_O == 2'h0; endproperty
  property p_narrow_hi; rd_done && narrow |-> AVS_READDATA_O[31:16] == 16'h0000; endproperty
  property p_centre_hi; rd_done && centre |-> AVS_READDATA_O[31:24] == 8'h00; endproperty
  property p_latency; take |-> ##2 RES_VALID_O; endproperty
  property p_hold; RES_VALID_O && !RES_READY_I |=> RES_VALID_O && $stable(RES_DATA_O); endproperty
  property p_limit; take |-> held < 3'h2; endproperty
  property p_quiet; disable iff (1'b0) !NRST_I |-> !RES_VALID_O && !SAMP_READY_O && !AVS_WAITREQUEST_O; endproperty
  a_wait_first: assert property (p_wait_first) else $error("waitrequest not one cycle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped read refused");
  a_narrow_hi: assert property (p_narrow_hi) else $error("upper half not zero");
  a_centre_hi: assert property (p_centre_hi) else $error("centre upper byte not zero");
  a_latency: assert property (p_latency) else $error("result late");
  a_hold: assert property (p_hold) else $error("result dropped while stalled");
  a_limit: assert property (p_limit) else $error("buffer overrun");
  a_quiet: assert property (p_quiet) else $error("outputs active in reset");
endmodule
bind fireq_top fireq_assertions u_chk (.CLOCK_I, .NRST_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
  .AVS_READDATA_O, .AVS_WAITREQUEST_O, .AVS_RESPONSE_O, .SAMP_VALID_I, .SAMP_READY_O, .RES_DATA_O,
  .RES_VALID_O, .RES_READY_I);

//--- bench/test_fir_equalizer_coefficient_bank.sv
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module test_fir_equalizer_coefficient_bank
  import fireq_pkg::*;
;
  // Reset starts high so that asserting it at time zero is a real falling edge
  logic                    CLOCK_I = 1'b0, NRST_I = 1'b1, AVS_READ_I = 1'b0, AVS_WRITE_I = 1'b0;
  logic [FIREQ_ADDR_W-1:0] AVS_ADDRESS_I = '0;
  logic [31:0]             AVS_WRITEDATA_I = 32'h0000_0000, AVS_READDATA_O, rd;
  logic [3:0]              AVS_BYTEENABLE_I = 4'hF, cyc = 4'h0;
  logic                    AVS_WAITREQUEST_O, SAMP_VALID_I = 1'b0, SAMP_READY_O, RES_VALID_O, RES_READY_I = 1'b0;
  logic [1:0]              AVS_RESPONSE_O, resp;
  fireq_samp_t             SAMP_DATA_I = '0;
  fireq_result_t           RES_DATA_O;
  fireq_result_t           got[$];
  int                      failures = 0, samples_checked = 0;
  int                      wb[5] = '{2047, -2048, -1, 3, -131072};
  logic [11:0]             idx_tab[6] = '{FIREQ_IDX_B0, FIREQ_IDX_B1, FIREQ_IDX_B2, FIREQ_IDX_B3, FIREQ_IDX_B4, FIREQ_IDX_A8};
  // Reserved bits set in some words: they must read back yet leave the weight's sign alone
  logic [31:0]             dat_tab[6] = '{32'h0000_F7FF, 32'h0000_0800, 32'h0000_0FFF, 32'h0000_A003,
                                          32'h00FE_0000, 32'h0000_5801};
  fireq_top dut (.CLOCK_I, .NRST_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I,
    .AVS_READDATA_O, .AVS_WAITREQUEST_O, .AVS_RESPONSE_O, .SAMP_DATA_I, .SAMP_VALID_I, .SAMP_READY_O,
    .RES_DATA_O, .RES_VALID_O, .RES_READY_I);
  always #5 CLOCK_I = ~CLOCK_I;
  // Receiver stalls four cycles in eight so the buffer fills and refuses
  always @(posedge CLOCK_I) begin
    cyc <= cyc + 4'h1;
    RES_READY_I <= cyc[2];
    if (RES_VALID_O === 1'b1 && RES_READY_I === 1'b1) got.push_back(RES_DATA_O);
  end
  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] d);
    @(posedge CLOCK_I);
    AVS_WRITE_I <= wr;
    AVS_READ_I <= !wr;
    AVS_ADDRESS_I <= {idx, 2'h0};
    AVS_WRITEDATA_I <= d;
    do @(posedge CLOCK_I); while (AVS_WAITREQUEST_O !== 1'b0);
    rd = AVS_READDATA_O;
    resp = AVS_RESPONSE_O;
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I <= 1'b0;
  endtask
  task automatic send(input logic [11:0] v);
    SAMP_VALID_I <= 1'b1;
    SAMP_DATA_I <= {v, v};
    do @(posedge CLOCK_I); while (SAMP_READY_O !== 1'b1);
  endtask
  // Impulse of -2048 after pre zeros; output k then shows tap weight k times the impulse
  task automatic run(input logic dual, input int pre);
    longint ea, eb;
    got.delete();
    for (int i = 0; i < pre + 10; i++) send(i == pre ? 12'h800 : 12'h000);
    SAMP_VALID_I <= 1'b0;
    while (got.size() < pre + 10) @(posedge CLOCK_I);
    for (int k = 0; k < 10; k++) begin
      ea = (k == 8) ? -2048 * -2047 : 0;
      eb = (dual && k < 5) ? -2048 * wb[k] : 0;
      `CHK(got[pre+k].a, 36'(ea))
      `CHK(got[pre+k].b, 36'(eb))
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge CLOCK_I);
    failures++;
    give_verdict();
  end
  initial begin
    NRST_I <= 1'b0;
    repeat (3) @(posedge CLOCK_I);
    NRST_I <= 1'b1;
    repeat (3) @(posedge CLOCK_I);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, idx_tab[i], 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
    end
    bus(1'b0, FIREQ_IDX_CTRL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    $display("reset values done");
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, idx_tab[i], dat_tab[i]);
      bus(1'b0, idx_tab[i], 32'h0000_0000);
      `CHK(rd, dat_tab[i])
    end
    bus(1'b0, 12'h0445, 32'h0000_0000);
    `CHK({resp, rd}, {2'h3, 32'h0000_0000})
    bus(1'b1, 12'h0445, 32'h0000_FFFF);
    `CHK(resp, 2'h3)
    // Only byte lane 1 is written: the low byte must survive
    AVS_BYTEENABLE_I <= 4'h2;
    bus(1'b1, FIREQ_IDX_B3, 32'h0000_5A77);
    AVS_BYTEENABLE_I <= 4'hF;
    bus(1'b0, FIREQ_IDX_B3, 32'h0000_0000);
    `CHK(rd, 32'h0000_5A03)
    bus(1'b1, FIREQ_IDX_B3, dat_tab[3]);
    $display("registers done");
    run(1'b1, 0);
    $display("dual mode done");
    bus(1'b1, FIREQ_IDX_CTRL, 32'h0000_0000);
    run(1'b0, 9);
    $display("single mode done");
    bus(1'b0, FIREQ_IDX_STATUS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    // Reset again once both runs are done: the B4 and A8 weights must be back to zero
    NRST_I <= 1'b0;
    repeat (3) @(posedge CLOCK_I);
    NRST_I <= 1'b1;
    repeat (3) @(posedge CLOCK_I);
    bus(1'b0, FIREQ_IDX_B4, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    bus(1'b0, FIREQ_IDX_A8, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    bus(1'b0, FIREQ_IDX_CTRL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    $display("second reset done");
    give_verdict();
  end
endmodule
